// >>> src/egp_pkg.sv
// package: register map, field layout, reset values and carrier types of the gpio port block
package egp_pkg;

    // ==========================================================
    // register word indices (byte address is four times the index)
    localparam logic [3:0] IDX_DATA = 4'h0;
    localparam logic [3:0] IDX_DIR  = 4'h1;
    localparam logic [3:0] IDX_PV   = 4'h2;
    localparam logic [3:0] IDX_DS   = 4'h3;
    localparam logic [3:0] IDX_SRE  = 4'h4;
    localparam logic [3:0] IDX_PFE  = 4'h5;
    localparam logic [3:0] IDX_IC   = 4'h6;
    localparam logic [3:0] IDX_IPE  = 4'h7;
    localparam logic [3:0] IDX_IF   = 4'h8;
    localparam logic [3:0] IDX_IES  = 4'h9;
    localparam logic [3:0] IDX_DFE  = 4'hA;
    localparam logic [3:0] IDX_DFC  = 4'hB;

    // ==========================================================
    // field positions
    localparam int IC_DMAEN_BIT = 7;
    localparam int IC_IE_BIT    = 1;
    localparam int IC_MOD_BIT   = 0;
    localparam int DFC_CLKS_BIT = 7;
    localparam int DFC_FF_MSB   = 4;
    localparam int DFC_FF_LSB   = 0;

    // ==========================================================
    // reset values
    localparam logic [7:0]  PORT_RST  = 8'h00;
    localparam logic [7:0]  DS_RST    = 8'h00;
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [4:0]  FF_RST    = 5'h00;
    localparam logic [5:0]  CNT_RST   = 6'h00;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] high_drive;
        logic [7:0] slew_limit;
        logic [7:0] passive_filter;
    } egp_pad_t;

    typedef struct packed {
        logic [7:0] own;
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] analog;
    } egp_alt_t;

    typedef struct packed {
        logic [7:0]      port_data_reg;
        logic [7:0]      port_direction_reg;
        logic [7:0]      drive_strength_select;
        logic [7:0]      slew_rate_enable;
        logic [7:0]      passive_filter_enable;
        logic            pin_dma_request_enable;
        logic            cpu_irq_enable;
        logic            detect_mode_select;
        logic [7:0]      pin_irq_enable;
        logic [7:0]      pin_irq_flags;
        logic [7:0]      pin_irq_polarity;
        logic [7:0]      glitch_filter_enable;
        logic            filter_clock_select;
        logic [4:0]      filter_factor;
        logic [7:0]      filt;
        logic [7:0][5:0] cnt;
        logic [7:0]      prev_asserted;
        logic            waitreq;
        logic [31:0]     rdata;
        egp_pad_t        pad;
        logic [7:0]      alt_in;
        logic            irq;
        logic            dma_req;
        logic            wake;
    } egp_state_t;

endpackage : egp_pkg

// >>> src/egp_port.sv
// module: eight-pin port with pin interrupt, dma request and glitch filters
`timescale 1ns/10ps
`default_nettype none

module egp_port (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [5:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    input  wire logic [3:0]       avs_byteenable,
    output var  logic [31:0]      avs_readdata,
    output var  logic             avs_waitrequest,
    input  wire logic [7:0]       pad_in,
    output var  egp_pkg::egp_pad_t pad_ctl,
    input  wire egp_pkg::egp_alt_t alt,
    output var  logic [7:0]       alt_in,
    input  wire logic             low_power_tick,
    input  wire logic             stop_mode,
    input  wire logic             dma_done,
    output var  logic             irq,
    output var  logic             dma_req,
    output var  logic             wake
);

    // ==========================================================
    // state and derived terms
    egp_pkg::egp_state_t st_r;
    egp_pkg::egp_state_t st_nxt;

    logic [7:0]       pin_is_input;
    logic [7:0]       in_path;
    logic [7:0]       digital_level;
    logic [7:0]       asserted_lvl;
    logic [7:0]       edge_hit;
    logic [7:0]       cond;
    logic [7:0]       flag_clr;
    logic [7:0]       filt_nxt;
    logic [7:0][5:0]  cnt_nxt;
    logic             tick;
    logic             bus_req;
    logic             bus_acc;
    logic             wr_acc;
    logic [3:0]       idx;
    logic [7:0]       wbyte;

    assign idx     = avs_address[5:2];
    assign wbyte   = avs_writedata[7:0];
    assign bus_req = avs_read | avs_write;
    // access takes effect on the cycle waitrequest is seen low
    assign bus_acc = bus_req & ~st_r.waitreq;
    assign wr_acc  = bus_acc & avs_write & avs_byteenable[0];

    // pin counts as input when nobody drives it
    assign pin_is_input = ~st_r.pad.oe;
    assign tick         = st_r.filter_clock_select ? low_power_tick : 1'b1;

    // ==========================================================
    // glitch filters, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_filt
            always_comb begin
                filt_nxt[gi] = st_r.filt[gi];
                cnt_nxt[gi]  = st_r.cnt[gi];
                if (!st_r.glitch_filter_enable[gi] || pad_in[gi] == st_r.filt[gi]) begin
                    // disabled filter tracks pad so enabling starts clean
                    filt_nxt[gi] = pad_in[gi];
                    cnt_nxt[gi]  = egp_pkg::CNT_RST;
                end else if (tick) begin
                    // a change must outlast factor+1 ticks to pass
                    if (st_r.cnt[gi] == {1'b0, st_r.filter_factor} + 6'h01) begin
                        filt_nxt[gi] = pad_in[gi];
                        cnt_nxt[gi]  = egp_pkg::CNT_RST;
                    end else begin
                        cnt_nxt[gi] = st_r.cnt[gi] + 6'h01;
                    end
                end
            end
            assign in_path[gi] = (st_r.glitch_filter_enable[gi] && pin_is_input[gi])
                               ? st_r.filt[gi] : pad_in[gi];
        end
    endgenerate

    // ==========================================================
    // pin interrupt detection
    assign digital_level = in_path & ~alt.analog;
    assign asserted_lvl  = ~(digital_level ^ st_r.pin_irq_polarity);
    assign edge_hit      = asserted_lvl & ~st_r.prev_asserted;
    assign cond          = st_r.pin_irq_enable
                         & (edge_hit | (st_r.detect_mode_select ? asserted_lvl : 8'h00));
    assign flag_clr      = (wr_acc && idx == egp_pkg::IDX_IF ? wbyte : 8'h00)
                         | {8{dma_done}};

    // ==========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.filt          = filt_nxt;
        st_nxt.cnt           = cnt_nxt;
        st_nxt.prev_asserted = asserted_lvl;
        // set beats clear; level mode re-sets while pin stays asserted
        st_nxt.pin_irq_flags = (st_r.pin_irq_flags & ~flag_clr) | cond;

        // bus: one wait cycle, then the access completes
        st_nxt.waitreq = ~(bus_req & st_r.waitreq);
        if (bus_req && st_r.waitreq) begin
            st_nxt.rdata = egp_pkg::RDATA_RST;
            unique case (idx)
                egp_pkg::IDX_DATA: st_nxt.rdata[7:0] =
                    (st_r.port_data_reg & st_r.port_direction_reg)
                  | (digital_level & ~st_r.port_direction_reg);
                egp_pkg::IDX_DIR: st_nxt.rdata[7:0] = st_r.port_direction_reg;
                egp_pkg::IDX_PV:  st_nxt.rdata[7:0] = pad_in & ~alt.analog;
                egp_pkg::IDX_DS:  st_nxt.rdata[7:0] = st_r.drive_strength_select;
                egp_pkg::IDX_SRE: st_nxt.rdata[7:0] = st_r.slew_rate_enable;
                egp_pkg::IDX_PFE: st_nxt.rdata[7:0] = st_r.passive_filter_enable;
                egp_pkg::IDX_IC: begin
                    st_nxt.rdata[egp_pkg::IC_DMAEN_BIT] = st_r.pin_dma_request_enable;
                    st_nxt.rdata[egp_pkg::IC_IE_BIT]    = st_r.cpu_irq_enable;
                    st_nxt.rdata[egp_pkg::IC_MOD_BIT]   = st_r.detect_mode_select;
                end
                egp_pkg::IDX_IPE: st_nxt.rdata[7:0] = st_r.pin_irq_enable;
                egp_pkg::IDX_IF:  st_nxt.rdata[7:0] = st_r.pin_irq_flags;
                egp_pkg::IDX_IES: st_nxt.rdata[7:0] = st_r.pin_irq_polarity;
                egp_pkg::IDX_DFE: st_nxt.rdata[7:0] = st_r.glitch_filter_enable;
                egp_pkg::IDX_DFC: begin
                    st_nxt.rdata[egp_pkg::DFC_CLKS_BIT] = st_r.filter_clock_select;
                    st_nxt.rdata[egp_pkg::DFC_FF_MSB:egp_pkg::DFC_FF_LSB] =
                        st_r.filter_factor;
                end
                default: st_nxt.rdata = egp_pkg::RDATA_RST;
            endcase
        end
        if (wr_acc) begin
            unique case (idx)
                egp_pkg::IDX_DATA: st_nxt.port_data_reg         = wbyte;
                egp_pkg::IDX_DIR:  st_nxt.port_direction_reg    = wbyte;
                egp_pkg::IDX_DS:   st_nxt.drive_strength_select = wbyte;
                egp_pkg::IDX_SRE:  st_nxt.slew_rate_enable      = wbyte;
                egp_pkg::IDX_PFE:  st_nxt.passive_filter_enable = wbyte;
                egp_pkg::IDX_IC: begin
                    st_nxt.pin_dma_request_enable = wbyte[egp_pkg::IC_DMAEN_BIT];
                    st_nxt.cpu_irq_enable         = wbyte[egp_pkg::IC_IE_BIT];
                    st_nxt.detect_mode_select     = wbyte[egp_pkg::IC_MOD_BIT];
                end
                egp_pkg::IDX_IPE:  st_nxt.pin_irq_enable        = wbyte;
                egp_pkg::IDX_IES:  st_nxt.pin_irq_polarity      = wbyte;
                egp_pkg::IDX_DFE:  st_nxt.glitch_filter_enable  = wbyte;
                egp_pkg::IDX_DFC: begin
                    st_nxt.filter_clock_select = wbyte[egp_pkg::DFC_CLKS_BIT];
                    st_nxt.filter_factor       =
                        wbyte[egp_pkg::DFC_FF_MSB:egp_pkg::DFC_FF_LSB];
                end
                // flags handled above; pin value and unmapped ignore writes
                default: ;
            endcase
        end

        // pad control: foreign owner wins, else irq pin forced input
        for (int i = 0; i < 8; i++) begin
            if (alt.own[i]) begin
                st_nxt.pad.oe[i]  = alt.oe[i];
                st_nxt.pad.out[i] = alt.out[i];
            end else begin
                st_nxt.pad.oe[i]  = st_r.port_direction_reg[i]
                                  & ~st_r.pin_irq_enable[i];
                st_nxt.pad.out[i] = st_r.port_direction_reg[i]
                                  & ~st_r.pin_irq_enable[i]
                                  & st_r.port_data_reg[i];
            end
        end
        st_nxt.pad.high_drive     = st_r.drive_strength_select & st_r.pad.oe;
        st_nxt.pad.slew_limit     = st_r.slew_rate_enable & st_r.pad.oe;
        st_nxt.pad.passive_filter = st_r.passive_filter_enable & pin_is_input;
        st_nxt.alt_in             = in_path;

        st_nxt.dma_req = st_r.pin_dma_request_enable & (|st_r.pin_irq_flags);
        st_nxt.irq     = ~st_r.pin_dma_request_enable & st_r.cpu_irq_enable
                       & (|st_r.pin_irq_flags);
        // clocks may stop here; wake is recomputed every cycle and drops once stop_mode or the asserted enabled pin goes away
        st_nxt.wake    = stop_mode & st_r.cpu_irq_enable
                       & (|(st_r.pin_irq_enable & asserted_lvl));
    end

    // ==========================================================
    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r                        <= '0;
            st_r.port_data_reg          <= egp_pkg::PORT_RST;
            st_r.port_direction_reg     <= egp_pkg::PORT_RST;
            st_r.drive_strength_select  <= egp_pkg::DS_RST;
            st_r.slew_rate_enable       <= egp_pkg::CTRL_RST;
            st_r.passive_filter_enable  <= egp_pkg::CTRL_RST;
            st_r.pin_irq_enable         <= egp_pkg::CTRL_RST;
            st_r.pin_irq_flags          <= egp_pkg::CTRL_RST;
            st_r.pin_irq_polarity       <= egp_pkg::CTRL_RST;
            st_r.glitch_filter_enable   <= egp_pkg::CTRL_RST;
            st_r.filter_factor          <= egp_pkg::FF_RST;
            st_r.rdata                  <= egp_pkg::RDATA_RST;
            st_r.waitreq                <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata    = st_r.rdata;
    assign avs_waitrequest = st_r.waitreq;
    assign pad_ctl         = st_r.pad;
    assign alt_in          = st_r.alt_in;
    assign irq             = st_r.irq;
    assign dma_req         = st_r.dma_req;
    assign wake            = st_r.wake;

    // ==========================================================
    // assertions
    sequence s_read_start(logic [3:0] i);
        avs_read && st_r.waitreq && idx == i;
    endsequence

    sequence s_answer;
        !avs_waitrequest;
    endsequence

    property p_dma_req;
        @(posedge clk) disable iff (rst)
        (st_r.pin_dma_request_enable && |st_r.pin_irq_flags) |=> dma_req;
    endproperty
    a_dma_req: assert property (p_dma_req) else $error("dma request missing");

    property p_dma_blocks_irq;
        @(posedge clk) disable iff (rst)
        st_r.pin_dma_request_enable |=> !irq;
    endproperty
    a_dma_blocks_irq: assert property (p_dma_blocks_irq)
        else $error("irq raised while dma enabled");

    property p_irq_mask;
        @(posedge clk) disable iff (rst)
        !st_r.cpu_irq_enable |=> !irq ##1 (irq == $past(~st_r.pin_dma_request_enable
            & st_r.cpu_irq_enable & (|st_r.pin_irq_flags)));
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("irq not masked");

    property p_irq_forced_input;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((st_r.pad.oe & $past(st_r.pin_irq_enable) & ~$past(alt.own)) == 8'h00);
    endproperty
    a_irq_forced_input: assert property (p_irq_forced_input)
        else $error("irq pin driven");

    property p_dir_drives;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((st_r.pad.oe & ~$past(alt.own)) ==
                  ($past(st_r.port_direction_reg & ~st_r.pin_irq_enable) & ~$past(alt.own)));
    endproperty
    a_dir_drives: assert property (p_dir_drives) else $error("direction not followed");

    property p_flag_set;
        @(posedge clk) disable iff (rst)
        (|cond) |=> ((st_r.pin_irq_flags & $past(cond)) == $past(cond));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("detected flag lost");

    property p_flag_zero_write;
        @(posedge clk) disable iff (rst)
        (wr_acc && idx == egp_pkg::IDX_IF && !dma_done)
        |=> ((st_r.pin_irq_flags & ~$past(wbyte)) == (($past(st_r.pin_irq_flags) & ~$past(wbyte))
             | ($past(cond) & ~$past(wbyte))));
    endproperty
    a_flag_zero_write: assert property (p_flag_zero_write)
        else $error("zero write changed flag");

    property p_glitch_hold;
        @(posedge clk) disable iff (rst)
        (st_r.glitch_filter_enable[0] && pad_in[0] != st_r.filt[0]
         && st_r.cnt[0] <= {1'b0, st_r.filter_factor})
        |=> st_r.filt[0] == $past(st_r.filt[0]);
    endproperty
    a_glitch_hold: assert property (p_glitch_hold) else $error("glitch passed filter");

    property p_off_tick_hold;
        @(posedge clk) disable iff (rst)
        (st_r.filter_clock_select && !low_power_tick && st_r.glitch_filter_enable[0]
         && pad_in[0] != st_r.filt[0]) |=> $stable(st_r.cnt[0]);
    endproperty
    a_off_tick_hold: assert property (p_off_tick_hold) else $error("filter counted off tick");

    property p_pin_value_read;
        logic [7:0] v;
        @(posedge clk) disable iff (rst)
        (s_read_start(egp_pkg::IDX_PV), v = pad_in & ~alt.analog)
        |=> s_answer ##0 (avs_readdata[7:0] == v) && (avs_readdata[31:8] == 24'h000000);
    endproperty
    a_pin_value_read: assert property (p_pin_value_read) else $error("pin value wrong");

    property p_wake;
        @(posedge clk) disable iff (rst)
        (stop_mode && st_r.cpu_irq_enable && |(st_r.pin_irq_enable & asserted_lvl)) |=> wake;
    endproperty
    a_wake: assert property (p_wake) else $error("stop wake missing");

    property p_drive_out;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((st_r.pad.high_drive & ~$past(st_r.pad.oe)) == 8'h00);
    endproperty
    a_drive_out: assert property (p_drive_out) else $error("drive on input pin");

    property p_slew_out;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((st_r.pad.slew_limit & ~$past(st_r.pad.oe)) == 8'h00);
    endproperty
    a_slew_out: assert property (p_slew_out) else $error("slew on input pin");

    property p_pfilt_in;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((st_r.pad.passive_filter & $past(st_r.pad.oe)) == 8'h00);
    endproperty
    a_pfilt_in: assert property (p_pfilt_in) else $error("pad filter on output");

    property p_out_forced;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((st_r.pad.out & $past(st_r.pin_irq_enable & ~alt.own)) == 8'h00);
    endproperty
    a_out_forced: assert property (p_out_forced) else $error("irq pin data driven");

    property p_flag_gated;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((st_r.pin_irq_flags
                  & ~$past(st_r.pin_irq_flags | st_r.pin_irq_enable)) == 8'h00);
    endproperty
    a_flag_gated: assert property (p_flag_gated) else $error("flag on disabled pin");

    property p_edge_only;
        @(posedge clk) disable iff (rst)
        (!st_r.detect_mode_select && wr_acc && idx == egp_pkg::IDX_IF)
        |=> ((st_r.pin_irq_flags & $past(wbyte & ~edge_hit)) == 8'h00);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("level re-set in edge mode");

    property p_dma_clear;
        @(posedge clk) disable iff (rst)
        (dma_done && cond == 8'h00) |=> (st_r.pin_irq_flags == 8'h00);
    endproperty
    a_dma_clear: assert property (p_dma_clear) else $error("dma done left flag");

    property p_glitch_pass;
        @(posedge clk) disable iff (rst)
        (st_r.glitch_filter_enable[0] && pad_in[0] != st_r.filt[0] && tick
         && st_r.cnt[0] == {1'b0, st_r.filter_factor} + 6'h01)
        |=> st_r.filt[0] == $past(pad_in[0]);
    endproperty
    a_glitch_pass: assert property (p_glitch_pass) else $error("long pulse blocked");

endmodule : egp_port

`default_nettype wire

// >>> tb/egp_pad_model.sv
// pad model: resolves pad levels from the port drive and the outside world
`timescale 1ns/10ps
`default_nettype none

module egp_pad_model (
    input  wire egp_pkg::egp_pad_t pad_ctl,
    input  wire logic [7:0]        ext,
    output var  logic [7:0]        pad_in
);
    // ==========================================
    // drive resolution
    // undriven pins take the outside level; no pull resistors are modelled
    always_comb begin
        pad_in = (pad_ctl.out & pad_ctl.oe) | (ext & ~pad_ctl.oe);
    end
endmodule : egp_pad_model

`default_nettype wire

// >>> tb/enhanced_gpio_port_pin_interrupt_test.sv
// testbench: register, pad, interrupt, filter and wake scenarios of the gpio port
`timescale 1ns/10ps
`default_nettype none

module enhanced_gpio_port_pin_interrupt_test;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [5:0]        avs_address = 6'h00;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = 32'h0000_0000;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [7:0]        pad_in;
    logic [7:0]        ext = 8'h00;
    egp_pkg::egp_pad_t pad_ctl;
    egp_pkg::egp_alt_t alt = '0;
    logic [7:0]        alt_in;
    logic              low_power_tick = 1'b0;
    logic              low_power_run = 1'b0;
    logic              stop_mode = 1'b0;
    logic              dma_done = 1'b0;
    logic              irq;
    logic              dma_req;
    logic              wake;
    int                fails = 0;
    int                total_checks = 0;
    int                seed_v;
    logic [7:0]        q;
    logic [7:0]        d;
    logic [7:0]        s;
    logic [7:0]        e;

    always #25 clk = ~clk;
    // low-power tick every second bus cycle while running
    always @(posedge clk) low_power_tick <= low_power_run & ~low_power_tick;

    egp_port uut (
        .clk             (clk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (4'h1),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .pad_in          (pad_in),
        .pad_ctl         (pad_ctl),
        .alt             (alt),
        .alt_in          (alt_in),
        .low_power_tick  (low_power_tick),
        .stop_mode       (stop_mode),
        .dma_done        (dma_done),
        .irq             (irq),
        .dma_req         (dma_req),
        .wake            (wake)
    );

    egp_pad_model pads (
        .pad_ctl (pad_ctl),
        .ext     (ext),
        .pad_in  (pad_in)
    );

    // ==========================================
    // expectation helpers
    function automatic logic [7:0] mix(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] sel);
        return (a & sel) | (b & ~sel);
    endfunction : mix

    // ==========================================
    // bus and compare tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] wd,
                       output logic [7:0] rd_v);
        int n;
        n = 0;
        @(posedge clk);
        avs_read      <= ~w;
        avs_write     <= w;
        avs_address   <= a;
        avs_writedata <= {24'h000000, wd};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("unexpected %0t bus hang", $time);
        end
        rd_v = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [7:0] wd);
        logic [7:0] dummy;
        bus(1'b1, a, wd, dummy);
    endtask : wr

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp, input string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %0t %s got %b", $time, m, got);
        end
    endtask : chk1

    task automatic flags(input logic [7:0] exp, input string m);
        bus(1'b0, 6'h20, 8'h00, q);
        chk8(q, exp, m);
    endtask : flags

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        $display("unexpected %0t watchdog", $time);
        stop_test();
    end

    // ==========================================
    // main sequence
    initial begin
        seed_v = $urandom(68176);
        cyc(3);
        rst <= 1'b0;
        bus(1'b0, 6'h0C, 8'h00, q);
        chk8(q, 8'h00, "drive reset");
        bus(1'b0, 6'h30, 8'h00, q);
        chk8(q, 8'h00, "unmapped");
        d = $urandom;
        s = $urandom;
        wr(6'h00, d);
        wr(6'h04, 8'hFF);
        wr(6'h0C, s);
        wr(6'h10, ~s);
        wr(6'h14, s);
        cyc(3);
        chk8(pad_ctl.oe, 8'hFF, "oe");
        chk8(pad_ctl.out & pad_ctl.oe, d, "out");
        wr(6'h04, 8'h0F);
        cyc(3);
        chk8(pad_ctl.high_drive, mix(s, 8'h00, 8'h0F), "drive");
        chk8(pad_ctl.slew_limit, mix(~s, 8'h00, 8'h0F), "slew");
        chk8(pad_ctl.passive_filter, mix(8'h00, s, 8'h0F), "pfilt");
        e = $urandom;
        ext <= e;
        cyc(2);
        bus(1'b0, 6'h08, 8'h00, q);
        chk8(q, mix(d, e, 8'h0F), "pin value");
        bus(1'b0, 6'h00, 8'h00, q);
        chk8(q, mix(d, e, 8'h0F), "data read");
        alt <= '{own: 8'h80, oe: 8'h00, out: 8'h00, analog: 8'h30};
        wr(6'h04, 8'h8F);
        cyc(3);
        chk8(pad_ctl.oe, 8'h0F, "foreign oe");
        bus(1'b0, 6'h08, 8'h00, q);
        chk8(q, mix(d, e, 8'h0F) & 8'hCF, "analog pv");
        bus(1'b0, 6'h00, 8'h00, q);
        chk1(q[7], d[7], "foreign data");
        alt <= '0;
        $display("test pads done");
        ext <= 8'h02;
        wr(6'h04, 8'hFF);
        wr(6'h24, 8'h01);
        wr(6'h1C, 8'h03);
        cyc(3);
        chk8(pad_ctl.oe, 8'hFC, "irq pins input");
        wr(6'h20, 8'hFF);
        wr(6'h18, 8'h02);
        ext <= 8'h03;
        cyc(4);
        flags(8'h01, "rise");
        chk1(irq, 1'b1, "irq");
        wr(6'h20, 8'h00);
        flags(8'h01, "w0");
        wr(6'h20, 8'h01);
        cyc(2);
        flags(8'h00, "w1c");
        chk1(irq, 1'b0, "irq off");
        ext <= 8'h05;
        cyc(4);
        flags(8'h02, "fall");
        wr(6'h18, 8'h00);
        cyc(2);
        chk1(irq, 1'b0, "masked");
        wr(6'h18, 8'h82);
        cyc(3);
        chk1(dma_req, 1'b1, "dma");
        chk1(irq, 1'b0, "dma blocks");
        dma_done <= 1'b1;
        cyc(1);
        dma_done <= 1'b0;
        cyc(3);
        flags(8'h00, "dma done");
        chk1(dma_req, 1'b0, "dma off");
        wr(6'h18, 8'h03);
        cyc(3);
        flags(8'h03, "level");
        wr(6'h20, 8'h03);
        flags(8'h03, "level held");
        ext <= 8'h02;
        wr(6'h18, 8'h02);
        wr(6'h20, 8'hFF);
        $display("test irq done");
        wr(6'h2C, 8'h02);
        wr(6'h28, 8'h01);
        ext <= 8'h03;
        cyc(3);
        chk1(alt_in[0], 1'b0, "glitch path");
        ext <= 8'h02;
        cyc(8);
        flags(8'h00, "glitch");
        ext <= 8'h03;
        cyc(4);
        ext <= 8'h02;
        cyc(8);
        flags(8'h01, "pulse");
        wr(6'h20, 8'hFF);
        wr(6'h2C, 8'h82);
        ext <= 8'h03;
        cyc(10);
        ext <= 8'h02;
        cyc(8);
        flags(8'h00, "no tick");
        low_power_run <= 1'b1;
        ext <= 8'h03;
        cyc(20);
        flags(8'h01, "tick");
        chk1(alt_in[0], 1'b1, "filtered path");
        $display("test filter done");
        wr(6'h28, 8'h00);
        ext <= 8'h02;
        wr(6'h18, 8'h82);
        stop_mode <= 1'b1;
        ext <= 8'h03;
        cyc(4);
        chk1(wake, 1'b1, "wake");
        stop_mode <= 1'b0;
        cyc(2);
        chk1(wake, 1'b0, "wake off");
        $display("test wake done");
        stop_test();
    end
endmodule : enhanced_gpio_port_pin_interrupt_test

`default_nettype wire
